/* File: common/dpc_pkg.sv */
// Purpose: shared constants and types for the dual-port RAM port controller
// Assumes: 125 MHz system clock, one port of an asynchronous 8K x 8 dual-port RAM
// Notes: pin timing figures are conservative defaults, adjust per speed grade
package dpc_pkg;

	localparam int ADDR_W = 13;
	localparam int DATA_W = 8;
	localparam int SEM_IDX_W = 3;
	localparam int CNT_W = 4;

	localparam logic [12:0] MBOX_LEFT_ADDR = 13'h1FFE;
	localparam logic [12:0] MBOX_RIGHT_ADDR = 13'h1FFF;

	localparam logic [7:0] SEM_TAKE_DATA = 8'h00;
	localparam logic [7:0] SEM_GIVE_DATA = 8'h01;

	localparam int CLK_PERIOD_NS = 8;
	localparam int ADDR_SETUP_NS = 20;
	localparam int WRITE_PULSE_NS = 40;
	localparam int READ_ACCESS_NS = 70;

	// Least times, rounded up to whole cycles
	localparam logic [3:0] SETUP_CYC = 4'((ADDR_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [3:0] PULSE_CYC = 4'((WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [3:0] ACCESS_CYC = 4'((READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [3:0] SYNC_LAT = 4'h2;
	localparam logic [3:0] READ_CYC = 4'(ACCESS_CYC + SYNC_LAT);

	typedef enum logic [2:0] {
		OP_MEM_RD,
		OP_MEM_WR,
		OP_MBOX_SEND,
		OP_MBOX_CLEAR,
		OP_SEM_TAKE,
		OP_SEM_GIVE,
		OP_SEM_READ
	} dpc_op_e;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_SETUP,
		ST_PULSE,
		ST_HOLD,
		ST_READ,
		ST_GAP
	} dpc_state_e;

	typedef struct packed {
		dpc_op_e op;
		logic [12:0] addr;
		logic [7:0] wdata;
	} dpc_cmd_s;

	typedef struct packed {
		logic [7:0] rdata;
		logic granted;
		logic retried;
	} dpc_rsp_s;

	typedef struct packed {
		logic select_n;
		logic sem_select_n;
		logic rw_n;
		logic oe_n;
		logic [12:0] addr;
		logic [7:0] dq_out;
		logic dq_oe_n;
	} dpc_pins_s;

	localparam dpc_pins_s PINS_IDLE = '{select_n: 1'h1, sem_select_n: 1'h1, rw_n: 1'h1,
		oe_n: 1'h1, addr: 13'h0000, dq_out: 8'h00, dq_oe_n: 1'h1};

endpackage

/* File: src/dpc_port_ctrl.sv */
// Purpose: drives one port of an 8K x 8 dual-port RAM: memory, mailbox and semaphore cycles
// Assumes: busy pins come from the single master of the array, all pins asynchronous
// Notes: a collided memory access is retried until it runs without busy
// Overview of operation
// - Right side clears by reading 1FFF
// - Slave inhibit input high normally, low blocks
// - Only one master per width-expanded array
// - Address and select settle before write pulse
// - Depth-cascaded busy lines are ANDed internally over the NBUSY inputs
`timescale 1ns/1ns
module dpc_port_ctrl
	import dpc_pkg::*;
#(
	parameter bit IS_LEFT = 1'b1,
	parameter bit IS_MASTER = 1'b1,
	parameter int NBUSY = 1
) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire dpc_cmd_s cmd,
	output logic rsp_valid,
	output dpc_rsp_s rsp,
	output logic mbox_pending,
	input wire logic lock_writes,
	output logic write_inhibit_n,
	output logic role_master,
	output dpc_pins_s pins,
	input wire logic [7:0] dq_in,
	input wire logic [NBUSY-1:0] busy_n,
	input wire logic mbox_irq_n
);
	localparam int SW = 1 + NBUSY + DATA_W;
	localparam logic [12:0] PARTNER_MBOX = IS_LEFT ? MBOX_RIGHT_ADDR : MBOX_LEFT_ADDR;
	localparam logic [12:0] OWN_MBOX = IS_LEFT ? MBOX_LEFT_ADDR : MBOX_RIGHT_ADDR;

	logic [SW-1:0] sync_w;
	logic irq_s;
	logic [NBUSY-1:0] busy_s;
	logic [7:0] dq_s;

	// Pins start at their inactive level, so no flag or busy is seen after reset
	dpc_sync #(.W(SW), .RST_VAL({SW{1'h1}})) u_sync (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.clk_en(clk_en),
		.async_in({mbox_irq_n, busy_n, dq_in}),
		.sync_out(sync_w)
	);
	assign {irq_s, busy_s, dq_s} = sync_w;

	dpc_state_e state_r, state_nxt;
	dpc_op_e op_r, op_nxt;
	logic [12:0] addr_r, addr_nxt;
	logic [7:0] wdata_r, wdata_nxt, rdata_r;
	logic is_write_r, is_write_nxt;
	logic phase2_r, phase2_nxt;
	logic again_r, again_nxt;
	logic retried_r, retried_nxt;
	logic [3:0] cnt_r, cnt_nxt;
	logic rsp_valid_r;
	dpc_pins_s pins_r, pins_nxt;

	// Decode of the incoming command
	wire cmd_fire = cmd_valid && cmd_ready;
	wire cmd_sem = (cmd.op == OP_SEM_TAKE) || (cmd.op == OP_SEM_GIVE) || (cmd.op == OP_SEM_READ);
	wire cmd_write = (cmd.op == OP_MEM_WR) || (cmd.op == OP_MBOX_SEND) ||
		(cmd.op == OP_SEM_TAKE) || (cmd.op == OP_SEM_GIVE);
	wire [12:0] cmd_addr = (cmd.op == OP_MBOX_SEND) ? PARTNER_MBOX :
		(cmd.op == OP_MBOX_CLEAR) ? OWN_MBOX :
		cmd_sem ? {10'h000, cmd.addr[SEM_IDX_W-1:0]} : cmd.addr;
	wire [7:0] cmd_wdata = (cmd.op == OP_SEM_TAKE) ? SEM_TAKE_DATA :
		(cmd.op == OP_SEM_GIVE) ? SEM_GIVE_DATA : cmd.wdata;

	wire op_sem = (op_r == OP_SEM_TAKE) || (op_r == OP_SEM_GIVE) || (op_r == OP_SEM_READ);
	// Any low busy of a depth cascade stalls the access
	wire busy_seen = !(&busy_s);
	// Semaphores never answer busy, so only memory cycles retry
	// Reads retry as well, since the master arbitrates on select and address only
	wire collided = busy_seen && !op_sem;
	wire cnt_done = (cnt_r == 4'h1);

	assign cmd_ready = (state_r == ST_IDLE) && clk_en;

	always_comb begin
		state_nxt = state_r;
		op_nxt = op_r;
		addr_nxt = addr_r;
		wdata_nxt = wdata_r;
		is_write_nxt = is_write_r;
		phase2_nxt = phase2_r;
		again_nxt = again_r;
		retried_nxt = retried_r;
		cnt_nxt = cnt_r;
		case (state_r)
			ST_IDLE: begin
				if (cmd_fire) begin
					state_nxt = ST_SETUP;
					op_nxt = cmd.op;
					addr_nxt = cmd_addr;
					wdata_nxt = cmd_wdata;
					is_write_nxt = cmd_write;
					phase2_nxt = 1'h0;
					retried_nxt = 1'h0;
					cnt_nxt = SETUP_CYC;
				end
			end
			ST_SETUP: begin
				// Write pulse starts only after the master has had time to flag busy
				if (!cnt_done) begin
					cnt_nxt = 4'(cnt_r - 4'h1);
				end else if (collided) begin
					state_nxt = ST_GAP;
					again_nxt = 1'h1;
					retried_nxt = 1'h1;
				end else if (is_write_r) begin
					state_nxt = ST_PULSE;
					cnt_nxt = PULSE_CYC;
				end else begin
					state_nxt = ST_READ;
					cnt_nxt = READ_CYC;
				end
			end
			ST_PULSE: begin
				if (cnt_done) begin
					state_nxt = ST_HOLD;
				end else begin
					cnt_nxt = 4'(cnt_r - 4'h1);
				end
			end
			ST_HOLD: begin
				state_nxt = ST_GAP;
				if (collided) begin
					// A busy arriving late means the write may have been gated
					again_nxt = 1'h1;
					retried_nxt = 1'h1;
				end else if (op_r == OP_SEM_TAKE && !phase2_r) begin
					// Request then verify: read back whether the token came to us
					again_nxt = 1'h1;
					phase2_nxt = 1'h1;
					is_write_nxt = 1'h0;
				end else begin
					again_nxt = 1'h0;
				end
			end
			ST_READ: begin
				if (cnt_done) begin
					state_nxt = ST_GAP;
					again_nxt = 1'h0;
				end else begin
					cnt_nxt = 4'(cnt_r - 4'h1);
				end
			end
			ST_GAP: begin
				// One standby cycle also releases the semaphore output latch
				// The master grants one side at a time, so a retry ends once the winner leaves
				if (again_r) begin
					state_nxt = ST_SETUP;
					cnt_nxt = SETUP_CYC;
					again_nxt = 1'h0;
				end else begin
					state_nxt = ST_IDLE;
				end
			end
			default: begin
				state_nxt = ST_IDLE;
			end
		endcase
	end

	// Strobes are registered so the asynchronous RAM never sees decode glitches
	wire nxt_active = (state_nxt == ST_SETUP) || (state_nxt == ST_PULSE) ||
		(state_nxt == ST_HOLD) || (state_nxt == ST_READ);
	wire nxt_sem = (op_nxt == OP_SEM_TAKE) || (op_nxt == OP_SEM_GIVE) || (op_nxt == OP_SEM_READ);
	assign pins_nxt.select_n = !(nxt_active && !nxt_sem);
	assign pins_nxt.sem_select_n = !(nxt_active && nxt_sem);
	assign pins_nxt.rw_n = !(state_nxt == ST_PULSE);
	assign pins_nxt.oe_n = !(state_nxt == ST_READ);
	assign pins_nxt.addr = addr_nxt;
	assign pins_nxt.dq_out = wdata_nxt;
	assign pins_nxt.dq_oe_n = !((state_nxt == ST_PULSE) || (state_nxt == ST_HOLD));

	wire read_done = (state_r == ST_READ) && cnt_done;
	wire finish = (state_r == ST_GAP) && !again_r;

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			state_r <= ST_IDLE;
			op_r <= OP_MEM_RD;
			addr_r <= 13'h0000;
			wdata_r <= 8'h00;
			is_write_r <= 1'h0;
			phase2_r <= 1'h0;
			again_r <= 1'h0;
			retried_r <= 1'h0;
			cnt_r <= 4'h0;
			pins_r <= PINS_IDLE;
		end else if (clk_en) begin
			state_r <= state_nxt;
			op_r <= op_nxt;
			addr_r <= addr_nxt;
			wdata_r <= wdata_nxt;
			is_write_r <= is_write_nxt;
			phase2_r <= phase2_nxt;
			again_r <= again_nxt;
			retried_r <= retried_nxt;
			cnt_r <= cnt_nxt;
			pins_r <= pins_nxt;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			rdata_r <= 8'h00;
			rsp_valid_r <= 1'h0;
			write_inhibit_n <= 1'h1;
			role_master <= 1'h0;
			mbox_pending <= 1'h0;
		end else if (clk_en) begin
			if (read_done) begin
				rdata_r <= dq_s;
			end
			rsp_valid_r <= finish;
			write_inhibit_n <= !lock_writes;
			role_master <= IS_MASTER;
			mbox_pending <= !irq_s;
		end
	end

	assign pins = pins_r;
	assign rsp_valid = rsp_valid_r;
	assign rsp.rdata = rdata_r;
	// Semaphore flag is active low: a zero read back means we hold it
	assign rsp.granted = op_sem && !rdata_r[0];
	assign rsp.retried = retried_r;

	// Helper: cycles that the memory or semaphore select has been low with write idle
	logic [3:0] sel_age_r;
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			sel_age_r <= 4'h0;
		end else if (clk_en) begin
			if (pins_r.select_n && pins_r.sem_select_n) begin
				sel_age_r <= 4'h0;
			end else if (pins_r.rw_n && sel_age_r != 4'hF) begin
				sel_age_r <= 4'(sel_age_r + 4'h1);
			end
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);

	a_write_setup:
		assert property ($fell(pins.rw_n) |-> sel_age_r >= SETUP_CYC)
		else $error("write pulse began before address setup");
	a_idle_standby:
		assert property (state_r == ST_IDLE && clk_en |-> pins.select_n && pins.sem_select_n)
		else $error("idle port not in standby");
	a_mbox_target:
		assert property (!pins.rw_n && op_r == OP_MBOX_SEND |-> pins.addr == PARTNER_MBOX)
		else $error("mailbox send to wrong address");
	a_clear_is_read:
		assert property (op_r == OP_MBOX_CLEAR && !pins.select_n |->
			pins.rw_n && pins.addr == OWN_MBOX)
		else $error("mailbox clear not a read of own mailbox");
	a_sem_bit_zero:
		assert property (!pins.sem_select_n && !pins.dq_oe_n |-> pins.dq_out[7:1] == 7'h00)
		else $error("semaphore write uses upper data bits");
	a_sem_index:
		assert property (!pins.sem_select_n |-> pins.addr[12:3] == 10'h000)
		else $error("semaphore address above bit 2");
	a_busy_no_write:
		assert property (clk_en && state_r == ST_SETUP && cnt_done && collided |=>
			pins.rw_n [*2])
		else $error("write pulse issued while busy");
	a_sem_release:
		assert property (clk_en && state_r == ST_GAP && op_sem |->
			pins.sem_select_n && pins.select_n)
		else $error("semaphore select not released between cycles");
	a_no_drive_on_read:
		assert property (!pins.oe_n |-> pins.dq_oe_n && pins.rw_n)
		else $error("data bus driven during read");

	c_mem_write: cover property (!pins.select_n ##1 $fell(pins.rw_n));
	c_busy_retry: cover property (state_r == ST_GAP && again_r && retried_r && !phase2_r);
	c_sem_granted: cover property (rsp_valid && op_r == OP_SEM_TAKE && rsp.granted);
	c_mbox_clear: cover property (rsp_valid && op_r == OP_MBOX_CLEAR);
endmodule

/* File: src/dpc_sync.sv */
// Purpose: two-flop synchroniser for asynchronous pin inputs
// Assumes: inputs are levels, multi-bit groups are only read once stable
// Notes: reset value is the inactive level of the pins
`timescale 1ns/1ns
module dpc_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '1
) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);
	logic [W-1:0] meta_r;

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			meta_r <= RST_VAL;
			sync_out <= RST_VAL;
		end else if (clk_en) begin
			meta_r <= async_in;
			sync_out <= meta_r;
		end
	end
endmodule

/* File: verif/dpc_ram_model.sv */
// Purpose: behavioural dual-port RAM on the controller's left port, right port from the bench
// Assumes: this part is the array master; its right port is driven by the bench
// Notes: sampled on the bench clock, so pin effects lag one cycle, except busy_l_n which is decoded from the pins directly
`timescale 1ns/1ns
module dpc_ram_model
	import dpc_pkg::*;
(
	input wire logic clk,
	input wire dpc_pins_s lp,
	input wire logic r_sel_n,
	input wire logic r_sem_n,
	input wire logic r_rw_n,
	input wire logic r_oe_n,
	input wire logic [12:0] r_addr,
	input wire logic [7:0] r_din,
	output logic [7:0] l_dq,
	output logic [7:0] r_dq,
	output logic busy_l_n,
	output logic left_mailbox_irq_n,
	output logic right_mailbox_irq_n
);
	logic [7:0] mem [0:8191];
	logic [7:0] lreq, rreq, lown, rown, lsem_q; // Eight flags
	logic r_win, lsem_rd_q;
	wire match = !lp.select_n && !r_sel_n && lp.addr == r_addr;
	wire lmw = !lp.select_n && !lp.rw_n;
	wire rmw = !r_sel_n && !r_rw_n;
	wire lsw = !lp.sem_select_n && !lp.rw_n;
	wire rsw = !r_sem_n && !r_rw_n;
	wire lrd = !lp.select_n && !lp.oe_n; // Unselected port does nothing
	wire lsem_rd = !lp.sem_select_n && !lp.oe_n;
	wire [2:0] li = lp.addr[2:0];
	wire [2:0] ri = r_addr[2:0];
	// Push-pull master output; only the later side is ever busied
	assign busy_l_n = !(match && r_win);
	initial begin
		{lreq, rreq, lown, rown, lsem_q, l_dq, r_dq} = '0;
		{r_win, lsem_rd_q} = 2'b00;
		left_mailbox_irq_n = 1'b1;
		right_mailbox_irq_n = 1'b1;
	end
	always @(posedge clk) begin
		if (!match)
			r_win <= !r_sel_n && lp.select_n;
		if (lmw && busy_l_n) // Busy side write is gated; semaphores gate nothing
			mem[lp.addr] <= lp.dq_out;
		if (rmw && !(match && !r_win))
			mem[r_addr] <= r_din;
		if (lmw && busy_l_n && lp.addr == MBOX_RIGHT_ADDR)
			right_mailbox_irq_n <= 1'b0;
		else if (!r_sel_n && !r_oe_n && r_rw_n && r_addr == MBOX_RIGHT_ADDR)
			right_mailbox_irq_n <= 1'b1;
		if (rmw && r_addr == MBOX_LEFT_ADDR)
			left_mailbox_irq_n <= 1'b0;
		else if (lrd && lp.addr == MBOX_LEFT_ADDR)
			left_mailbox_irq_n <= 1'b1;
		if (lsw)
			lreq[li] <= !lp.dq_out[0];
		if (rsw)
			rreq[ri] <= !r_din[0];
		lsem_rd_q <= lsem_rd;
		if (lsem_rd && !lsem_rd_q)
			lsem_q <= {8{!lown[li]}};
		// Released bus shows the inverse of the last value, never a stale match
		l_dq <= lsem_rd ? (lsem_rd_q ? lsem_q : {8{!lown[li]}}) : (lrd ? mem[lp.addr] : ~l_dq);
		r_dq <= (!r_sel_n && !r_oe_n) ? mem[r_addr] : ~r_dq;
	end
	always @(posedge clk) begin // Token follows the request latches, left wins a tie
		for (int i = 0; i < 8; i++) begin
			if (!lown[i] && !rown[i]) begin
				lown[i] <= lreq[i];
				rown[i] <= rreq[i] && !lreq[i];
			end else if (lown[i] && !lreq[i]) begin
				lown[i] <= 1'b0;
				rown[i] <= rreq[i];
			end else if (rown[i] && !rreq[i]) begin
				rown[i] <= 1'b0;
				lown[i] <= lreq[i];
			end
		end
	end
endmodule

/* File: verif/dual_port_ram_coordination_test.sv */
// Purpose: self-checking bench for the left port controller against the RAM model
// Assumes: inputs change at the falling edge, outputs are read there too
// Notes: the bench plays the right-hand processor directly on the model's pins
`timescale 1ns/1ns
module dual_port_ram_coordination_test;
	import dpc_pkg::*;
	logic sys_clk, sys_rst, clk_en, cmd_valid, cmd_ready, rsp_valid, mbox_pending;
	logic lock_writes, write_inhibit_n, role_master, busy_l_n, l_irq_n, r_irq_n;
	logic r_sel_n, r_sem_n, r_rw_n, r_oe_n;
	logic [12:0] r_addr;
	logic [7:0] r_din, r_dq, l_dq, q;
	dpc_cmd_s cmd;
	dpc_rsp_s rsp;
	dpc_pins_s pins;
	int bad_count = 0;
	int total_checks = 0;
	dpc_port_ctrl #(.IS_LEFT(1'b1), .IS_MASTER(1'b1), .NBUSY(1)) DUT (.sys_clk(sys_clk),
		.sys_rst(sys_rst), .clk_en(clk_en), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
		.cmd(cmd), .rsp_valid(rsp_valid), .rsp(rsp), .mbox_pending(mbox_pending),
		.lock_writes(lock_writes), .write_inhibit_n(write_inhibit_n),
		.role_master(role_master), .pins(pins), .dq_in(l_dq), .busy_n(busy_l_n),
		.mbox_irq_n(l_irq_n));
	dpc_ram_model RAM (.clk(sys_clk), .lp(pins), .r_sel_n(r_sel_n), .r_sem_n(r_sem_n),
		.r_rw_n(r_rw_n), .r_oe_n(r_oe_n), .r_addr(r_addr), .r_din(r_din), .l_dq(l_dq),
		.r_dq(r_dq), .busy_l_n(busy_l_n), .left_mailbox_irq_n(l_irq_n),
		.right_mailbox_irq_n(r_irq_n));
	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end
	task automatic final_report();
		if (bad_count == 0 && total_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic chk(input logic c, input string m);
		total_checks++;
		if (c !== 1'b1) begin
			bad_count++;
			$display("unexpected %0t %s", $time, m);
		end
	endtask
	task automatic run(input dpc_op_e op, input logic [12:0] a, input logic [7:0] d);
		int n;
		n = 0;
		cmd = '{op: op, addr: a, wdata: d};
		cmd_valid = 1'b1;
		while (cmd_ready !== 1'b1 && n < 400) begin
			@(negedge sys_clk);
			n++;
		end
		@(negedge sys_clk);
		cmd_valid = 1'b0;
		while (rsp_valid !== 1'b1 && n < 400) begin
			@(negedge sys_clk);
			n++;
		end
		chk(n < 400, "command timeout");
		if (n >= 400)
			final_report();
	endtask
	// Control order {select, semaphore select, write, read-enable}, all active low
	task automatic rdrive(input logic [3:0] c, input logic [12:0] a, input logic [7:0] d,
		input int n, output logic [7:0] v);
		{r_sel_n, r_sem_n, r_rw_n, r_oe_n} = c;
		r_addr = a;
		r_din = d;
		repeat (n) @(negedge sys_clk);
		v = r_dq;
		{r_sel_n, r_sem_n, r_rw_n, r_oe_n} = 4'hF;
		@(negedge sys_clk);
	endtask
	task automatic t_mem();
		chk(pins.select_n === 1'b1 && pins.sem_select_n === 1'b1, "not in standby");
		run(OP_MEM_WR, 13'h0123, 8'hA5);
		run(OP_MEM_RD, 13'h0123, 8'h00);
		chk(rsp.rdata === 8'hA5, "memory readback");
	endtask
	task automatic t_mbox();
		run(OP_MBOX_SEND, 13'h0000, 8'h3C);
		chk(r_irq_n === 1'b0, "right irq not set");
		rdrive(4'h6, MBOX_RIGHT_ADDR, 8'h00, 3, q);
		chk(q === 8'h3C, "mailbox word to right");
		chk(r_irq_n === 1'b1, "right irq not cleared");
		rdrive(4'h5, MBOX_LEFT_ADDR, 8'h77, 3, q);
		repeat (5) @(negedge sys_clk);
		chk(mbox_pending === 1'b1, "left irq not seen");
		run(OP_MBOX_CLEAR, 13'h0000, 8'h00);
		chk(rsp.rdata === 8'h77, "mailbox word to left");
		repeat (4) @(negedge sys_clk);
		chk(mbox_pending === 1'b0, "left irq not cleared");
	endtask
	task automatic t_sem();
		rdrive(4'h9, 13'h0003, 8'h00, 2, q);
		run(OP_SEM_TAKE, 13'h1AC3, 8'h00);
		chk(rsp.rdata === 8'hFF && rsp.granted === 1'b0, "held flag taken");
		rdrive(4'h9, 13'h0003, 8'h01, 2, q);
		run(OP_SEM_READ, 13'h0003, 8'h00);
		chk(rsp.rdata === 8'h00, "token not passed");
		run(OP_SEM_GIVE, 13'h0003, 8'h00);
		run(OP_SEM_TAKE, 13'h1FF5, 8'h00);
		chk(rsp.granted === 1'b1 && rsp.rdata === 8'h00, "free flag refused");
		run(OP_SEM_GIVE, 13'h1FF5, 8'h00);
	endtask
	task automatic t_busy();
		run(OP_MEM_WR, 13'h0200, 8'h33);
		fork
			rdrive(4'h6, 13'h0200, 8'h00, 40, q);
			begin
				repeat (3) @(negedge sys_clk);
				run(OP_MEM_WR, 13'h0200, 8'h11);
			end
		join
		chk(q === 8'h33, "busy write landed");
		chk(rsp.retried === 1'b1, "collision not retried");
		run(OP_MEM_RD, 13'h0200, 8'h00);
		chk(rsp.rdata === 8'h11, "retried write lost");
	endtask
	task automatic t_role();
		chk(role_master === 1'b1, "role pin");
		lock_writes = 1'b1;
		repeat (2) @(negedge sys_clk);
		chk(write_inhibit_n === 1'b0, "inhibit not driven");
		lock_writes = 1'b0;
		repeat (2) @(negedge sys_clk);
		chk(write_inhibit_n === 1'b1, "inhibit stuck");
		clk_en = 1'b0;
		lock_writes = 1'b1;
		repeat (2) @(negedge sys_clk);
		chk(cmd_ready === 1'b0 && write_inhibit_n === 1'b1, "enable low did not freeze");
		clk_en = 1'b1;
		lock_writes = 1'b0;
		@(negedge sys_clk);
	endtask
	initial begin
		{sys_rst, clk_en, cmd_valid, lock_writes} = 4'h0;
		sys_rst = 1'b1;
		clk_en = 1'b1;
		cmd = '0;
		{r_sel_n, r_sem_n, r_rw_n, r_oe_n} = 4'hF;
		r_addr = 13'h0000;
		r_din = 8'h00;
		repeat (12) @(negedge sys_clk);
		sys_rst = 1'b0;
		@(negedge sys_clk);
		t_mem();
		t_mbox();
		t_sem();
		t_busy();
		t_role();
		final_report();
	end
endmodule
